// ---- core/apd_ctrl.v ----
// power-down and clock-mode control for a 10-bit sar converter
`timescale 1ns/10ps
`default_nettype none
`include "apd_ctrl_map.vh"
module apd_ctrl #(
    parameter CONV_CYCLES = `APD_CONV_CYCLES
) (
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // pre-sensed shutdown pin, serial link (outside the ref_clk domain)
    input wire [1:0] hw_shutdown_pin,
    input wire sclk,
    input wire din,
    input wire cs_n,
    // control byte from the serial framer, same domain
    input wire ctrl_valid,
    input wire [7:0] ctrl_byte,
    // result from the sar core, same domain
    input wire [9:0] sar_result,
    // status and control outputs
    output reg powered_r,
    output reg hw_pd_r,
    output reg sw_pd_r,
    output reg light_sleep_mode,
    output reg deep_sleep_mode,
    output reg int_comp_r,
    output reg int_clk_mode_r,
    output reg iclk_r,
    output reg converting_r,
    output reg conv_done_r,
    output reg [9:0] result_r,
    output wire serial_active,
    output wire start_seen
);
    // ************************************************
    // input synchronisation
    // ************************************************
    wire [1:0] pin_s;
    wire sclk_s;
    wire din_s;
    wire cs_n_s;
    // one synchroniser for all five lines; skew between them is at most one cycle
    apd_sync #(.WIDTH(5)) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .d_in({hw_shutdown_pin, sclk, din, cs_n}),
        .d_out({pin_s, sclk_s, din_s, cs_n_s})
    );
    // edge detector rests low like the idle link clock, so reset gives no false edge
    reg sclk_d_r;
    wire sclk_rise = sclk_s & ~sclk_d_r;
    wire pin_low = (pin_s == `APD_PIN_LOW);
    wire pin_high = (pin_s == `APD_PIN_HIGH);

    // ************************************************
    // state machine
    // ************************************************
    localparam ST_IDLE = 4'h1;
    localparam ST_CONV = 4'h2;
    localparam ST_SWPD = 4'h4;
    localparam ST_HWPD = 4'h8;
    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg [1:0] mode_r;
    reg [1:0] mode_nxt;
    // pending control bits wait here until the running conversion ends
    reg [1:0] pend_r;
    reg [1:0] pend_nxt;
    reg [7:0] cnt_r;
    reg [7:0] cnt_nxt;
    // start bit only counts in sleep with cs low, and never in hardware power-down
    assign start_seen = (state_r == ST_SWPD) & sclk_rise & din_s & ~cs_n_s;
    // interface stays up in sleep only under internal clock mode
    assign serial_active = ~hw_pd_r & ((state_r != ST_SWPD) | int_clk_mode_r);

    // next-state logic: pin low is tested first so it overrides any control byte
    always @* begin
        state_nxt = state_r;
        mode_nxt = mode_r;
        pend_nxt = pend_r;
        cnt_nxt = cnt_r;
        if (pin_low) begin
            // pin low wins over every control byte, conversion dropped on the spot
            state_nxt = ST_HWPD;
            cnt_nxt = 8'h00;
        end else begin
            case (state_r)
                ST_HWPD: begin
                    // no settling wait here; the host owns the power-up delays
                    state_nxt = ST_IDLE;
                end
                ST_IDLE: begin
                    if (ctrl_valid) begin
                        pend_nxt = ctrl_byte[`APD_MODE_HI_POS:`APD_MODE_LO_POS];
                        state_nxt = ST_CONV;
                        cnt_nxt = CONV_CYCLES[7:0];
                    end
                end
                ST_SWPD: begin
                    if (start_seen) begin
                        state_nxt = ST_IDLE;
                    end
                end
                ST_CONV: begin
                    if (cnt_r > 8'h01) begin
                        cnt_nxt = cnt_r - 8'h01;
                    end else begin
                        // new mode takes effect only once the conversion ends
                        cnt_nxt = 8'h00;
                        mode_nxt = pend_r;
                        if (pend_r[1]) begin
                            state_nxt = ST_IDLE;
                        end else begin
                            state_nxt = ST_SWPD;
                        end
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************
    // internal conversion clock
    // ************************************************
    reg [7:0] div_r;
    // half periods round down, so both rates come out slightly fast
    wire [7:0] half = pin_high ? `APD_ICLK_HIGH_HALF : `APD_ICLK_OPEN_HALF;

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_r <= 8'h00;
            iclk_r <= 1'b0;
        end else begin
            // divider idles in hardware power-down so no clock reaches the sar
            if (pin_low || div_r + 8'h01 >= half) begin
                div_r <= 8'h00;
                // restarts low, so the sar sees a clean first edge on wake
                iclk_r <= ~pin_low & ~iclk_r;
            end else begin
                div_r <= div_r + 8'h01;
            end
        end
    end

    // ************************************************
    // state registers
    // ************************************************
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            mode_r <= `APD_RST_MODE;
            pend_r <= `APD_RST_MODE;
            cnt_r <= 8'h00;
            sclk_d_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            mode_r <= mode_nxt;
            pend_r <= pend_nxt;
            cnt_r <= cnt_nxt;
            sclk_d_r <= sclk_s;
        end
    end

    // ************************************************
    // status outputs
    // ************************************************
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            powered_r <= 1'b0;
            hw_pd_r <= 1'b1;
            sw_pd_r <= 1'b0;
            light_sleep_mode <= 1'b0;
            deep_sleep_mode <= 1'b0;
            int_comp_r <= 1'b0;
            int_clk_mode_r <= 1'b1;
            converting_r <= 1'b0;
            conv_done_r <= 1'b0;
            result_r <= 10'h000;
        end else begin
            // flags follow the next state so they change with the state register
            powered_r <= ~pin_low & (state_nxt != ST_SWPD);
            hw_pd_r <= pin_low;
            sw_pd_r <= (state_nxt == ST_SWPD);
            light_sleep_mode <= (state_nxt == ST_SWPD) & (mode_nxt == `APD_MODE_LIGHT);
            deep_sleep_mode <= (state_nxt == ST_SWPD) & (mode_nxt == `APD_MODE_DEEP);
            int_comp_r <= pin_high;
            // sleep codes name no clock mode, so the last clock mode is kept through sleep
            if (mode_nxt[`APD_MODE_HI_POS]) begin
                int_clk_mode_r <= (mode_nxt != `APD_MODE_EXTCLK);
            end
            converting_r <= (state_nxt == ST_CONV);
            conv_done_r <= (state_r == ST_CONV) & (state_nxt != ST_CONV) & ~pin_low;
            if ((state_r == ST_CONV) && (state_nxt != ST_CONV) && !pin_low) begin
                // straight binary, kept as is for unipolar and bipolar alike
                result_r <= sar_result;
            end
        end
    end
endmodule
`default_nettype wire

// ---- core/apd_ctrl_map.vh ----
// constants for the converter power-down and clock-mode control block
`ifndef APD_CTRL_MAP_VH
`define APD_CTRL_MAP_VH
// control byte: mode bits position
`define APD_MODE_HI_POS 1
`define APD_MODE_LO_POS 0
// mode decode of the two low control bits
`define APD_MODE_DEEP 2'h0
`define APD_MODE_LIGHT 2'h1
`define APD_MODE_INTCLK 2'h2
`define APD_MODE_EXTCLK 2'h3
// sensed shutdown pin states
`define APD_PIN_LOW 2'h0
`define APD_PIN_HIGH 2'h1
`define APD_PIN_OPEN 2'h2
// internal and reference clock rates in khz
`define APD_ICLK_HIGH_KHZ 225
`define APD_ICLK_OPEN_KHZ 1800
`define APD_REF_CLK_KHZ 20000
// internal clock half periods in ref_clk cycles, ref rate over twice the clock rate, rounded down
`define APD_ICLK_HIGH_HALF 8'h2c
`define APD_ICLK_OPEN_HALF 8'h05
// reset mode, result width and default conversion length
`define APD_RST_MODE 2'h2
`define APD_RESULT_BITS 10
`define APD_CONV_CYCLES 12
`endif

// ---- core/apd_sync.v ----
// two-flop synchroniser for inputs from outside the ref_clk domain
`timescale 1ns/10ps
`default_nettype none
module apd_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // data
    input wire [WIDTH-1:0] d_in,
    output wire [WIDTH-1:0] d_out
);
    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_r <= {WIDTH{1'b0}};
            sync_r <= {WIDTH{1'b0}};
        end else begin
            meta_r <= d_in;
            sync_r <= meta_r;
        end
    end
    assign d_out = sync_r;
endmodule
`default_nettype wire

// ---- tb/apd_ctrl_sva.sv ----
// assertion checker for the power-down control block
`timescale 1ns/10ps
`default_nettype none
module apd_ctrl_sva #(parameter CONV_CYCLES = 12) (
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // watched outputs
    input wire powered_r,
    input wire hw_pd_r,
    input wire sw_pd_r,
    input wire light_sleep_mode,
    input wire deep_sleep_mode,
    input wire int_clk_mode_r,
    input wire serial_active,
    input wire converting_r,
    input wire conv_done_r,
    input wire start_seen
);
    // **********
    // properties
    // **********
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_HWPD_IDLE: assert property (hw_pd_r |-> !converting_r && !conv_done_r)
        else $error("conversion active in hardware power-down");
    AST_CONV_LEN: assert property ($rose(converting_r) |-> ##CONV_CYCLES (conv_done_r || hw_pd_r))
        else $error("conversion length wrong");
    AST_DONE_PULSE: assert property (conv_done_r |=> !conv_done_r)
        else $error("done longer than one cycle");
    AST_MODE_ONEHOT: assert property (sw_pd_r |-> light_sleep_mode ^ deep_sleep_mode)
        else $error("sleep kind not one of two");
    AST_WAKE: assert property (start_seen |=> !sw_pd_r && (powered_r || hw_pd_r))
        else $error("start bit did not wake");
    AST_NOSTART_HW: assert property (hw_pd_r |-> !start_seen)
        else $error("start bit seen in hardware power-down");
    AST_PIN_PRIO: assert property (hw_pd_r |-> !powered_r)
        else $error("powered while pin low");
    AST_SLEEP_DONE: assert property ($rose(sw_pd_r) |-> conv_done_r)
        else $error("sleep entered before conversion end");
    AST_SLEEP_SERIAL: assert property (sw_pd_r && int_clk_mode_r |-> serial_active)
        else $error("serial interface off in internal clock sleep");
    AST_SLEEP_QUIET: assert property (sw_pd_r && !int_clk_mode_r |-> !serial_active)
        else $error("serial interface on in external clock sleep");
endmodule
`default_nettype wire

// ---- tb/apd_host_model.sv ----
// host model that sends a start bit on the serial link
`timescale 1ns/10ps
`default_nettype none
module apd_host_model (
    // serial link
    output logic sclk = 1'b0,
    output logic din = 1'b0,
    output logic cs_n = 1'b1
);
    // **********
    // start bit
    // **********
    // link clock stands still between frames, 400 ns period inside
    task automatic send_start();
        cs_n = 1'b0;
        din = 1'b1;
        #200 sclk = 1'b1;
        #200 sclk = 1'b0;
        din = 1'b0; // not selected: line shows the inverse of the last bit
        cs_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// ---- tb/tb_apd_ctrl.sv ----
// self-checking bench for the power-down control block
`timescale 1ns/10ps
`default_nettype none
`include "apd_ctrl_map.vh"
module tb_apd_ctrl;
    localparam int CC = 4;
    logic ref_clk = 1'b0, rst = 1'b1, ctrl_valid = 1'b0, sclk, din, cs_n, powered_r, hw_pd_r, sw_pd_r;
    logic light_sleep_mode, deep_sleep_mode, int_comp_r, int_clk_mode_r, iclk_r, converting_r, conv_done_r;
    logic serial_active, start_seen;
    logic [1:0] hw_shutdown_pin = `APD_PIN_HIGH;
    logic [7:0] ctrl_byte = 8'h00;
    logic [9:0] sar_result = 10'h000, result_r;
    int n_errors = 0, check_count = 0, cyc = 0, n;
    logic clk_int = 1'b1;
    apd_ctrl #(.CONV_CYCLES(CC)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .hw_shutdown_pin(hw_shutdown_pin), .sclk(sclk), .din(din), .cs_n(cs_n),
        .ctrl_valid(ctrl_valid), .ctrl_byte(ctrl_byte), .sar_result(sar_result), .powered_r(powered_r),
        .hw_pd_r(hw_pd_r), .sw_pd_r(sw_pd_r), .light_sleep_mode(light_sleep_mode), .deep_sleep_mode(deep_sleep_mode),
        .int_comp_r(int_comp_r), .int_clk_mode_r(int_clk_mode_r), .iclk_r(iclk_r), .converting_r(converting_r),
        .conv_done_r(conv_done_r), .result_r(result_r), .serial_active(serial_active), .start_seen(start_seen)
    );
    apd_host_model host_u (
        .sclk(sclk), .din(din), .cs_n(cs_n)
    );
    // **********
    // clock, timeout and tasks
    // **********
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            end_of_test();
        end
    end
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // entered on a rising edge; latency counted from the take edge
    task automatic convert(input logic [1:0] m, input logic [9:0] v);
        ctrl_byte <= {6'h20, m};
        sar_result <= v;
        ctrl_valid <= 1'b1;
        @(posedge ref_clk);
        ctrl_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
            #1;
        end while (!conv_done_r && n < 40);
        if (m[1]) clk_int = (m != 2'h3);
        chk(n, CC);
        chk(result_r, v);
        chk(sw_pd_r, !m[1]);
        chk(powered_r, m[1]);
        chk(light_sleep_mode, m == 2'h1);
        chk(deep_sleep_mode, m == 2'h0);
        chk(int_clk_mode_r, clk_int);
        chk(serial_active, m[1] | clk_int);
    endtask
    // phase offset keeps the link unrelated to ref_clk
    task automatic wake(input logic exp);
        #13 host_u.send_start();
        @(posedge ref_clk);
        #1 chk(powered_r, exp);
    endtask
    // **********
    // sequence
    // **********
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (40) @(posedge ref_clk);
        for (int p = 1; p <= 2; p++) begin
            hw_shutdown_pin <= p[1:0];
            repeat (100) @(posedge ref_clk);
            @(posedge iclk_r);
            n = 0;
            do begin
                @(posedge ref_clk);
                n++;
                #1;
            end while (iclk_r && n < 200);
            chk(n, p == 1 ? `APD_ICLK_HIGH_HALF : `APD_ICLK_OPEN_HALF);
            chk(int_comp_r, p == 1);
        end
        repeat (1500) @(posedge ref_clk);
        for (int m = 0; m < 4; m++) begin
            @(posedge ref_clk);
            convert(m[1:0], m[0] ? 10'h3ff : 10'h000);
            if (!m[1]) wake(1'b1);
        end
        @(posedge ref_clk);
        ctrl_byte <= 8'h82;
        sar_result <= 10'h0aa;
        ctrl_valid <= 1'b1;
        @(posedge ref_clk);
        ctrl_valid <= 1'b0;
        hw_shutdown_pin <= `APD_PIN_LOW;
        repeat (CC + 4) @(posedge ref_clk);
        #1 chk(hw_pd_r, 1'b1);
        chk(converting_r, 1'b0);
        chk(result_r, 10'h3ff);
        chk(iclk_r, 1'b0);
        chk(serial_active, 1'b0);
        wake(1'b0);
        @(posedge ref_clk);
        hw_shutdown_pin <= `APD_PIN_HIGH;
        repeat (40) @(posedge ref_clk);
        convert(2'h1, 10'h2aa);
        repeat (32000) @(posedge ref_clk);
        wake(1'b1);
        @(posedge ref_clk);
        convert(2'h2, 10'h155);
        end_of_test();
    end
endmodule
bind apd_ctrl apd_ctrl_sva #(.CONV_CYCLES(CONV_CYCLES)) sva_u (
    .ref_clk(ref_clk), .rst(rst), .powered_r(powered_r), .hw_pd_r(hw_pd_r), .sw_pd_r(sw_pd_r),
    .light_sleep_mode(light_sleep_mode), .deep_sleep_mode(deep_sleep_mode), .int_clk_mode_r(int_clk_mode_r),
    .serial_active(serial_active), .converting_r(converting_r), .conv_done_r(conv_done_r), .start_seen(start_seen)
);
`default_nettype wire
